// ### include/conv_ctrl_pkg.sv
// Package with register map, field layout and timing constants of the converter control
package conv_ctrl_pkg;
  localparam logic [3:0] OFS_CONFIG    = 4'h0;
  localparam logic [3:0] OFS_SC1       = 4'h4;
  localparam logic [3:0] OFS_SC2       = 4'h8;
  localparam logic [3:0] OFS_RES_HIGH  = 4'hC;
  localparam logic [5:0] OFS_RES_LOW   = 6'h10;
  localparam logic [5:0] OFS_PIN_ONE   = 6'h14;
  localparam logic [5:0] OFS_PIN_TWO   = 6'h18;
  localparam logic [5:0] OFS_CMP_HIGH  = 6'h1C;
  localparam logic [5:0] OFS_CMP_LOW   = 6'h20;
  localparam logic [5:0] OFS_POWER     = 6'h24;
  localparam int CFG_LOW_POWER  = 7;
  localparam int CFG_DIV_LSB    = 5;
  localparam int CFG_LONG_SMP   = 4;
  localparam int CFG_MODE_LSB   = 2;
  localparam int CFG_CLK_LSB    = 0;
  localparam int SC1_COMPLETE   = 7;
  localparam int SC1_IRQ_EN     = 6;
  localparam int SC1_CONT       = 5;
  localparam int SC2_HW_TRIG    = 6;
  localparam int SC2_CMP_EN     = 5;
  localparam int SC2_CMP_GT     = 4;
  localparam logic [1:0] MODE_8BIT   = 2'h0;
  localparam logic [1:0] MODE_10BIT  = 2'h2;
  localparam logic [1:0] CLK_ASYNC   = 2'h3;
  localparam logic [4:0] CHAN_OFF    = 5'h1F;
  localparam logic [7:0] RESET_CONFIG = 8'h00;
  localparam logic [7:0] RESET_SC1    = 8'h1F;
  localparam logic [9:0] FULL_10     = 10'h3FF;
  localparam logic [9:0] FULL_8      = 10'h0FF;
  localparam logic [9:0] ZERO_CODE   = 10'h000;
  // Sample windows in half converter clocks: 3.5 and 23.5 cycles
  localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
  localparam logic [5:0] SAMPLE_LONG_HALF  = 6'h2F;
  localparam logic [3:0] BITS_10 = 4'hA;
  localparam logic [3:0] BITS_8  = 4'h8;
  typedef enum logic [1:0] {
    PWR_RUN   = 2'h0,
    PWR_STOP3 = 2'h1,
    PWR_STOP12 = 2'h2
  } power_mode_e;
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;
  typedef struct packed {
    logic [9:0] code;
    logic       above_high;
    logic       below_low;
  } analog_in_s;
endpackage

// ### rtl/conv_ctrl.sv
// Converter control: registers, stop-mode handling, sampling and result transfer
`timescale 1ns/1ns
module conv_ctrl (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RSTN,
  input  wire conv_ctrl_pkg::wb_req_s     WB_REQ,
  output logic                            WB_ACK,
  output logic [31:0]                     WB_DAT_O,
  input  wire conv_ctrl_pkg::power_mode_e POWER_MODE,
  input  wire logic                       HW_TRIGGER,
  input  wire logic                       ASYNC_CLK_TICK,
  input  wire conv_ctrl_pkg::analog_in_s  ANALOG_IN,
  output logic [4:0]                      CHANNEL_SELECT,
  output logic                            SAMPLE_ON,
  output logic                            LOW_POWER_SELECT,
  output logic [15:0]                     DIGITAL_IO_DISABLE,
  output logic                            CONV_IRQ
);
  import conv_ctrl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_e;

  conv_state_e state;
  conv_state_e next_state;
  logic [7:0]  converter_config;
  logic [7:0]  converter_status_control_one;
  logic [7:0]  converter_status_control_two;
  logic [7:0]  pin_control_one;
  logic [7:0]  pin_control_two;
  logic [7:0]  compare_value_high;
  logic [7:0]  compare_value_low;
  logic [9:0]  result;
  logic        read_block;
  logic [5:0]  half_count;
  logic [3:0]  div_count;
  logic [3:0]  bit_count;
  logic        ack;
  power_mode_e mode_prev;

  // Bus decode
  wire         access      = WB_REQ.cyc && WB_REQ.stb && !ack;
  wire         wr          = access && WB_REQ.we && WB_REQ.sel[0];
  wire         rd          = access && !WB_REQ.we;
  wire         wr_config   = wr && (WB_REQ.adr == {2'h0, OFS_CONFIG});
  wire         wr_sc1      = wr && (WB_REQ.adr == {2'h0, OFS_SC1});
  wire         wr_sc2      = wr && (WB_REQ.adr == {2'h0, OFS_SC2});
  wire         wr_cmp_high = wr && (WB_REQ.adr == OFS_CMP_HIGH);
  wire         wr_cmp_low  = wr && (WB_REQ.adr == OFS_CMP_LOW);
  wire         rd_high     = rd && (WB_REQ.adr == {2'h0, OFS_RES_HIGH});
  wire         rd_low      = rd && (WB_REQ.adr == OFS_RES_LOW);

  // Field extraction
  wire [1:0]   clk_select  = converter_config[CFG_CLK_LSB +: 2];
  wire [1:0]   div_field   = converter_config[CFG_DIV_LSB +: 2];
  wire [1:0]   res_mode    = converter_config[CFG_MODE_LSB +: 2];
  wire         long_sample = converter_config[CFG_LONG_SMP];
  wire         ten_bit     = (res_mode == MODE_10BIT);
  wire         async_sel   = (clk_select == CLK_ASYNC);
  wire         irq_enable  = converter_status_control_one[SC1_IRQ_EN];
  wire         continuous  = converter_status_control_one[SC1_CONT];
  wire [4:0]   channel     = converter_status_control_one[4:0];
  wire         hw_mode     = converter_status_control_two[SC2_HW_TRIG];
  wire         cmp_enable  = converter_status_control_two[SC2_CMP_EN];
  wire         cmp_greater = converter_status_control_two[SC2_CMP_GT];

  // Power mode interpretation
  wire         in_stop3    = (POWER_MODE == PWR_STOP3);
  wire         in_stop12   = (POWER_MODE == PWR_STOP12);
  wire         stop3_abort = in_stop3 && !async_sel;
  wire         stop3_entry = in_stop3 && (mode_prev != PWR_STOP3);

  // Converter clock: bus or async tick, divided by 1,2,4,8
  wire         src_tick    = async_sel ? ASYNC_CLK_TICK : 1'b1;
  wire [3:0]   div_limit   = 4'((4'h1 << div_field) - 4'h1);
  wire         conv_tick   = src_tick && (div_count == div_limit);

  // Abort on any mode change write or stop3 with bus clock
  wire         abort       = wr_config || wr_sc2 || wr_cmp_high || wr_cmp_low
                             || stop3_abort;
  wire         sw_start    = wr_sc1 && (WB_REQ.dat[4:0] != CHAN_OFF) && !hw_mode;
  // Stop3 halts only bus-clocked starts; async mode keeps triggering
  wire         hw_start    = hw_mode && HW_TRIGGER && (channel != CHAN_OFF)
                             && !stop3_abort;
  wire [5:0]   sample_end  = long_sample ? SAMPLE_LONG_HALF : SAMPLE_SHORT_HALF;
  wire [3:0]   bits_needed = ten_bit ? BITS_10 : BITS_8;
  wire         conv_done   = (state == ST_CONVERT) && conv_tick
                             && (bit_count == 4'(bits_needed - 4'h1));

  // Clamp the analog code to the selected resolution
  wire [9:0]   full_scale  = ten_bit ? FULL_10 : FULL_8;
  wire [9:0]   raw_code    = ten_bit ? ANALOG_IN.code : {2'h0, ANALOG_IN.code[9:2]};
  wire [9:0]   clamped     = ANALOG_IN.above_high ? full_scale :
                             ANALOG_IN.below_low ? ZERO_CODE : raw_code;
  wire [9:0]   cmp_value   = {compare_value_high[1:0], compare_value_low};
  wire [9:0]   cmp_diff    = 10'(clamped - cmp_value);
  wire         cmp_true    = cmp_greater ? (clamped >= cmp_value) : (clamped < cmp_value);
  wire         blocked     = ten_bit && read_block;
  wire         transfer    = conv_done && !blocked && (!cmp_enable || cmp_true);
  // Blocked results retry; failed single compare ends the run
  wire         rerun       = conv_done && (continuous || blocked);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (sw_start || hw_start || (continuous && stop3_entry && async_sel && 1'b0))
          next_state = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (conv_tick && half_count >= 6'(sample_end - 6'h1))
          next_state = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (conv_done)
          next_state = rerun ? ST_SAMPLE : ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (abort)
      next_state = ST_IDLE;
    if (sw_start)
      next_state = ST_SAMPLE;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state     <= ST_IDLE;
      mode_prev <= PWR_RUN;
    end else if (in_stop12) begin
      state     <= ST_IDLE;
      mode_prev <= POWER_MODE;
    end else begin
      state     <= next_state;
      mode_prev <= POWER_MODE;
    end
  end

  // Converter clock divider
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_count <= 4'h0;
    end else if (in_stop12) begin
      div_count <= 4'h0;
    end else if (src_tick) begin
      div_count <= conv_tick ? 4'h0 : 4'(div_count + 4'h1);
    end
  end

  // Window and bit counters; a software restart always opens a fresh window
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      half_count <= 6'h0;
      bit_count  <= 4'h0;
    end else if (in_stop12 || (next_state != state) || sw_start) begin
      half_count <= 6'h0;
      bit_count  <= 4'h0;
    end else if (conv_tick) begin
      // Two half-cycle counts per converter clock round the windows up to 4 and 24 clocks
      if (state == ST_SAMPLE)
        half_count <= 6'(half_count + 6'h2);
      if (state == ST_CONVERT)
        bit_count <= 4'(bit_count + 4'h1);
    end
  end

  // Write decode for the plain registers
  wire         wr_pin_one  = wr && (WB_REQ.adr == OFS_PIN_ONE);
  wire         wr_pin_two  = wr && (WB_REQ.adr == OFS_PIN_TWO);
  // Bit 0 of control two is the busy readback, never stored
  wire [7:0]   sc2_write   = {WB_REQ.dat[7:4], 4'h0};

  // Configuration; stop1/stop2 acts as a synchronous reset
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      converter_config <= RESET_CONFIG;
    end else if (in_stop12) begin
      converter_config <= RESET_CONFIG;
    end else if (wr_config) begin
      converter_config <= WB_REQ.dat[7:0];
    end
  end

  // Control two: trigger and compare options
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      converter_status_control_two <= 8'h00;
    end else if (in_stop12) begin
      converter_status_control_two <= 8'h00;
    end else if (wr_sc2) begin
      converter_status_control_two <= sc2_write;
    end
  end

  // Pin control one
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_control_one <= 8'h00;
    end else if (in_stop12) begin
      pin_control_one <= 8'h00;
    end else if (wr_pin_one) begin
      pin_control_one <= WB_REQ.dat[7:0];
    end
  end

  // Pin control two
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_control_two <= 8'h00;
    end else if (in_stop12) begin
      pin_control_two <= 8'h00;
    end else if (wr_pin_two) begin
      pin_control_two <= WB_REQ.dat[7:0];
    end
  end

  // Compare value, high byte; only bits 1:0 take part in the compare
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      compare_value_high <= 8'h00;
    end else if (in_stop12) begin
      compare_value_high <= 8'h00;
    end else if (wr_cmp_high) begin
      compare_value_high <= WB_REQ.dat[7:0];
    end
  end

  // Compare value, low byte
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      compare_value_low <= 8'h00;
    end else if (in_stop12) begin
      compare_value_low <= 8'h00;
    end else if (wr_cmp_low) begin
      compare_value_low <= WB_REQ.dat[7:0];
    end
  end

  // Control one: a write clears the flag, but a transfer in the same cycle wins
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      converter_status_control_one <= RESET_SC1;
    end else if (in_stop12) begin
      converter_status_control_one <= RESET_SC1;
    end else begin
      if (transfer)
        converter_status_control_one[SC1_COMPLETE] <= 1'b1;
      else if (wr_sc1 || rd_low)
        converter_status_control_one[SC1_COMPLETE] <= 1'b0;
      if (wr_sc1)
        converter_status_control_one[6:0] <= WB_REQ.dat[6:0];
    end
  end

  // Result and read blocking; stop3 never touches either
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      result     <= 10'h000;
      read_block <= 1'b0;
    end else if (in_stop12) begin
      result     <= 10'h000;
      read_block <= 1'b0;
    end else begin
      if (transfer)
        result <= cmp_enable ? cmp_diff : clamped;
      if (rd_high && ten_bit)
        read_block <= 1'b1;
      else if (rd_low)
        read_block <= 1'b0;
    end
  end

  // Bus answer: one wait state, unmapped reads return zero
  wire [7:0] read_byte =
    (WB_REQ.adr == {2'h0, OFS_CONFIG}) ? converter_config :
    (WB_REQ.adr == {2'h0, OFS_SC1})    ? converter_status_control_one :
    (WB_REQ.adr == {2'h0, OFS_SC2})    ? {converter_status_control_two[7:1],
                                          state != ST_IDLE} :
    (WB_REQ.adr == {2'h0, OFS_RES_HIGH}) ? {6'h00, result[9:8]} :
    (WB_REQ.adr == OFS_RES_LOW)        ? result[7:0] :
    (WB_REQ.adr == OFS_PIN_ONE)        ? pin_control_one :
    (WB_REQ.adr == OFS_PIN_TWO)        ? pin_control_two :
    (WB_REQ.adr == OFS_CMP_HIGH)       ? compare_value_high :
    (WB_REQ.adr == OFS_CMP_LOW)        ? compare_value_low :
    (WB_REQ.adr == OFS_POWER)          ? {6'h00, POWER_MODE} : 8'h00;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack <= 1'b0;
    end else begin
      ack <= access;
    end
  end

  // Data loads with a taken request and is zeroed otherwise, so it is valid in the ack cycle only
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_DAT_O <= access ? {24'h000000, read_byte} : 32'h0000_0000;
    end
  end

  assign WB_ACK             = ack;
  assign CHANNEL_SELECT     = channel;
  assign SAMPLE_ON          = (state == ST_SAMPLE);
  assign LOW_POWER_SELECT   = converter_config[CFG_LOW_POWER];
  assign DIGITAL_IO_DISABLE = {pin_control_two, pin_control_one};
  assign CONV_IRQ           = converter_status_control_one[SC1_COMPLETE] && irq_enable;
endmodule // conv_ctrl

// ### testbench/analog_source_model.sv
// Analog channel source and async converter clock model
`timescale 1ns/1ns
module analog_source_model
  import conv_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       tick_en,
  input  wire logic [4:0] channel,
  output analog_in_s      analog,
  output logic            tick
);
  logic [1:0] div = 2'h0;
  // Async clock slower than the bus clock, silent unless enabled
  always @(posedge clk) div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
  assign tick = tick_en && div == 2'h0;
  // Raw code is never full scale, so clamping must come from the flags
  assign analog.code = {channel, 5'h0A};
  assign analog.above_high = channel == 5'h02;
  assign analog.below_low = channel == 5'h03;
endmodule // analog_source_model

// ### testbench/conv_ctrl_props.sv
// Port-level checker for the converter control
`timescale 1ns/1ns
module conv_ctrl_props
  import conv_ctrl_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  input wire wb_req_s     WB_REQ,
  input wire logic        WB_ACK,
  input wire logic [31:0] WB_DAT_O,
  input wire power_mode_e POWER_MODE,
  input wire logic        HW_TRIGGER,
  input wire logic        ASYNC_CLK_TICK,
  input wire analog_in_s  ANALOG_IN,
  input wire logic [4:0]  CHANNEL_SELECT,
  input wire logic        SAMPLE_ON,
  input wire logic        LOW_POWER_SELECT,
  input wire logic [15:0] DIGITAL_IO_DISABLE,
  input wire logic        CONV_IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic [7:0] cfg;
  logic       irq_en;
  wire take = WB_REQ.cyc && WB_REQ.stb && !WB_ACK;
  wire wr = take && WB_REQ.we && WB_REQ.sel[0] && POWER_MODE != PWR_STOP12;
  wire wr_cfg = wr && WB_REQ.adr == 6'(OFS_CONFIG);
  wire wr_sc1 = wr && WB_REQ.adr == 6'(OFS_SC1);
  wire short_bus = cfg[6:4] == 3'h0 && cfg[1:0] == 2'h0;
  // Shadow of the fields the assertions depend on
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg <= RESET_CONFIG;
      irq_en <= 1'b0;
    end else if (POWER_MODE == PWR_STOP12) begin
      cfg <= RESET_CONFIG;
      irq_en <= 1'b0;
    end else begin
      if (wr_cfg) cfg <= WB_REQ.dat[7:0];
      if (wr_sc1) irq_en <= WB_REQ.dat[SC1_IRQ_EN];
    end
  end
  AST_ACK_NEXT: assert property (take |=> WB_ACK)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack longer than one cycle");
  AST_LOW_POWER: assert property (wr_cfg |=> LOW_POWER_SELECT == $past(WB_REQ.dat[7]))
    else $error("low power bit not from config bit 7");
  AST_CHANNEL: assert property (wr_sc1 |=> CHANNEL_SELECT == $past(WB_REQ.dat[4:0]))
    else $error("channel field wrong");
  AST_PIN_ONE: assert property (wr && WB_REQ.adr == OFS_PIN_ONE
    |=> DIGITAL_IO_DISABLE[7:0] == $past(WB_REQ.dat[7:0]))
    else $error("pin control not applied");
  AST_STOP12: assert property (POWER_MODE == PWR_STOP12 |=> CHANNEL_SELECT == CHAN_OFF
    && !LOW_POWER_SELECT && DIGITAL_IO_DISABLE == 16'h0 && !SAMPLE_ON && !CONV_IRQ)
    else $error("stop1/2 did not reset block");
  AST_STOP3_IDLE: assert property (POWER_MODE == PWR_STOP3 && cfg[1:0] != CLK_ASYNC
    |=> !SAMPLE_ON)
    else $error("sampling continued in stop3 on bus clock");
  // Natural end of a short window only; aborts end it early on purpose
  AST_SAMPLE_SHORT: assert property ($fell(SAMPLE_ON) && short_bus && !$past(wr)
    && $past(POWER_MODE) == PWR_RUN |-> $past(SAMPLE_ON, 4) && !$past(SAMPLE_ON, 5))
    else $error("short sample window not four cycles");
  AST_IRQ_ENABLE: assert property (CONV_IRQ |-> irq_en)
    else $error("interrupt while disabled");
  AST_IRQ_CLEAR: assert property (wr_sc1 |=> !CONV_IRQ)
    else $error("control one write left flag set");
endmodule // conv_ctrl_props
bind conv_ctrl conv_ctrl_props u_conv_ctrl_props (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .WB_REQ(WB_REQ), .WB_ACK(WB_ACK), .WB_DAT_O(WB_DAT_O), .POWER_MODE(POWER_MODE),
  .HW_TRIGGER(HW_TRIGGER), .ASYNC_CLK_TICK(ASYNC_CLK_TICK), .ANALOG_IN(ANALOG_IN),
  .CHANNEL_SELECT(CHANNEL_SELECT), .SAMPLE_ON(SAMPLE_ON),
  .LOW_POWER_SELECT(LOW_POWER_SELECT), .DIGITAL_IO_DISABLE(DIGITAL_IO_DISABLE),
  .CONV_IRQ(CONV_IRQ));

// ### testbench/test_conv_ctrl.sv
// Self-checking bench for the converter control
`timescale 1ns/1ns
module test_conv_ctrl;
  import conv_ctrl_pkg::*;
  logic        clk, rstn, trig, tick_en, ack, smp, lp, irq, tick;
  wb_req_s     req;
  power_mode_e pm;
  logic [31:0] dato;
  logic [4:0]  chan;
  logic [15:0] dio;
  analog_in_s  ain;
  int          fail_count, checks_done;
  conv_ctrl u_conv_ctrl (.SYS_CLK(clk), .RSTN(rstn), .WB_REQ(req), .WB_ACK(ack),
    .WB_DAT_O(dato), .POWER_MODE(pm), .HW_TRIGGER(trig), .ASYNC_CLK_TICK(tick),
    .ANALOG_IN(ain), .CHANNEL_SELECT(chan), .SAMPLE_ON(smp), .LOW_POWER_SELECT(lp),
    .DIGITAL_IO_DISABLE(dio), .CONV_IRQ(irq));
  analog_source_model u_analog_source_model (.clk(clk), .tick_en(tick_en),
    .channel(chan), .analog(ain), .tick(tick));
  function automatic logic [9:0] code(input logic [4:0] ch);
    return {ch, 5'h0A};
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dato[7:0];
    req <= '0;
    chk("ack", {15'h0, ack}, 16'h1);
    if (ack !== 1'b1) conclude;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(n, {8'h0, q}, {8'h0, e});
  endtask
  task automatic res(input logic [9:0] c);
    rdc("result high", 6'(OFS_RES_HIGH), {6'h0, c[9:8]});
    rdc("result low", OFS_RES_LOW, c[7:0]);
  endtask
  task automatic wirq(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < lim);
    chk("irq", {15'h0, irq}, 16'h1);
    if (irq !== 1'b1) conclude;
  endtask
  task automatic quiet(input int lim);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      if (irq !== 1'b0) seen = 1'b1;
    end
    chk("irq quiet", {15'h0, seen}, 16'h0);
  endtask
  task automatic smplen(input int e);
    int n;
    n = 0;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    do @(posedge clk); while (smp !== 1'b1 && ++n < 50);
    chk("sample start", {15'h0, smp}, 16'h1);
    if (smp !== 1'b1) conclude;
    n = 0;
    while (smp === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    chk("sample cycles", 16'(n), 16'(e));
  endtask
  task automatic t_reset;
    rdc("config", 6'(OFS_CONFIG), RESET_CONFIG);
    rdc("control one", 6'(OFS_SC1), RESET_SC1);
    rdc("unmapped", 6'h3C, 8'h00);
    chk("channel", {11'h0, chan}, {11'h0, CHAN_OFF});
  endtask
  task automatic t_single;
    wr(6'(OFS_CONFIG), 8'h08);
    wr(6'(OFS_SC2), 8'h00);
    wr(6'(OFS_SC1), 8'h45);
    wirq(200);
    res(code(5'h05));
    chk("flag cleared", {15'h0, irq}, 16'h0);
    quiet(80);
  endtask
  task automatic t_clamp;
    logic [19:0] tbl [3];
    tbl = '{{8'h08, 2'h2, FULL_10}, {8'h08, 2'h3, ZERO_CODE}, {8'h00, 2'h2, FULL_8}};
    foreach (tbl[i]) begin
      wr(6'(OFS_CONFIG), tbl[i][19:12]);
      wr(6'(OFS_SC1), {6'h10, tbl[i][11:10]});
      wirq(200);
      res(tbl[i][9:0]);
    end
  endtask
  task automatic t_sample;
    wr(6'(OFS_CONFIG), 8'h98);
    wr(6'(OFS_SC2), 8'h40);
    wr(6'(OFS_SC1), 8'h06);
    chk("low power", {15'h0, lp}, 16'h1);
    smplen(24);
    wr(6'(OFS_CONFIG), 8'h08);
    smplen(4);
    wr(6'(OFS_SC2), 8'h00);
  endtask
  task automatic t_block;
    wr(6'(OFS_SC1), 8'h45);
    wirq(200);
    rdc("result high", 6'(OFS_RES_HIGH), 8'h00);
    wr(6'(OFS_SC1), 8'h46);
    quiet(80);
    rdc("result low", OFS_RES_LOW, 8'(code(5'h05)));
  endtask
  task automatic t_stop3_abort;
    wr(6'(OFS_SC1), 8'h48);
    wirq(200);
    res(code(5'h08));
    wr(6'(OFS_CONFIG), 8'h98);
    wr(6'(OFS_SC1), 8'h47);
    pm <= PWR_STOP3;
    repeat (40) @(posedge clk);
    chk("sampling", {15'h0, smp}, 16'h0);
    pm <= PWR_RUN;
    quiet(100);
    res(code(5'h08));
  endtask
  task automatic t_stop3_async;
    tick_en <= 1'b1;
    wr(6'(OFS_CONFIG), 8'h0B);
    wr(6'(OFS_SC1), 8'h49);
    pm <= PWR_STOP3;
    wirq(600);
    res(code(5'h09));
    pm <= PWR_RUN;
    wr(6'(OFS_SC1), 8'h6A);
    pm <= PWR_STOP3;
    wirq(600);
    res(code(5'h0A));
    wirq(600);
    pm <= PWR_RUN;
    wr(6'(OFS_SC2), 8'h40);
    wr(6'(OFS_SC1), 8'h4B);
    pm <= PWR_STOP3;
    trig <= 1'b1;
    wirq(600);
    trig <= 1'b0;
    pm <= PWR_RUN;
    res(code(5'h0B));
    tick_en <= 1'b0;
  endtask
  task automatic t_stop12;
    wr(6'(OFS_PIN_ONE), 8'h02);
    wr(6'(OFS_PIN_TWO), 8'h80);
    chk("pin disable", dio, 16'h8002);
    wr(6'(OFS_CONFIG), 8'h98);
    pm <= PWR_STOP12;
    repeat (3) @(posedge clk);
    pm <= PWR_RUN;
    @(posedge clk);
    chk("pins after stop", dio, 16'h0000);
    rdc("config", 6'(OFS_CONFIG), RESET_CONFIG);
    rdc("control two", 6'(OFS_SC2), 8'h00);
    wr(6'(OFS_CONFIG), 8'h08);
    wr(6'(OFS_SC1), 8'h45);
    wirq(200);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #900000;
    fail_count++;
    conclude;
  end
  initial begin
    req = '0;
    pm = PWR_RUN;
    trig = 1'b0;
    tick_en = 1'b0;
    rstn = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_single;
    t_clamp;
    t_sample;
    t_block;
    t_stop3_abort;
    t_stop3_async;
    t_stop12;
    conclude;
  end
endmodule // test_conv_ctrl
